// ===== src/sps_top.sv
// Purpose: status pin source select registers and pin drivers
// Assumes: AXI4-Lite slave, all indicators synchronous to ref_clk
// Notes:   one write and one read answered at a time
//
// Local design decision: the AXI4-Lite register port.
`default_nettype none
module sps_top (
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic [9:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [9:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire sps_pkg::sps_ind_t ind,
  input  wire logic              signal_detector_bypass,
  input  wire sps_pkg::sps_test_t test_a,
  input  wire sps_pkg::sps_test_t test_b,
  output var  logic              status_pin_a,
  output var  logic              status_pin_b,
  output var  logic              irq
);
  import sps_pkg::*;

  typedef enum logic [2:0] {
    W_IDLE = 3'b001,
    W_RESP = 3'b010,
    W_HOLD = 3'b100
  } sps_wst_t;

  sps_wst_t              wst_ff;
  logic                  aw_got_ff;
  logic                  w_got_ff;
  logic [7:0]            waddr_ff;
  logic [31:0]           wdata_ff;
  logic                  wstrb0_ff;
  logic [1:0]            bresp_ff;
  logic                  rvalid_ff;
  logic [31:0]           rdata_ff;
  logic [1:0]            rresp_ff;
  sps_pin_cfg_t          cfg_a_ff;
  sps_pin_cfg_t          cfg_b_ff;
  logic [NUM_EVT-1:0]    irq_st_ff;
  logic [NUM_EVT-1:0]    irq_msk_ff;
  logic [NUM_EVT-1:0]    evt_prev_ff;
  logic [NUM_EVT-1:0]    evt_now;
  logic [NUM_EVT-1:0]    evt_rise;
  logic [NUM_EVT-1:0]    st_clr;
  logic                  wr_fire;
  logic                  addr_ok_w;
  logic [7:0]            ridx;
  logic [31:0]           nxt_rdata;
  logic                  nxt_rok;
  sps_ind_t              ind_eff;

  // Write channel: address and data taken in either order
  assign s_axi_awready = (wst_ff == W_IDLE) && !aw_got_ff;
  assign s_axi_wready  = (wst_ff == W_IDLE) && !w_got_ff;
  assign wr_fire   = (wst_ff == W_HOLD);
  assign addr_ok_w = (waddr_ff == IDX_PIN_A) || (waddr_ff == IDX_PIN_B) ||
                     (waddr_ff == IDX_IRQ_ST) || (waddr_ff == IDX_IRQ_MSK);

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wst_ff    <= W_IDLE;
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      waddr_ff  <= 8'h00;
      wdata_ff  <= 32'h0000_0000;
      wstrb0_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else begin
      unique case (wst_ff)
        W_IDLE: begin
          if (s_axi_awvalid && s_axi_awready) begin
            aw_got_ff <= 1'b1;
            waddr_ff  <= s_axi_awaddr[9:2];
          end
          if (s_axi_wvalid && s_axi_wready) begin
            w_got_ff  <= 1'b1;
            wdata_ff  <= s_axi_wdata;
            wstrb0_ff <= s_axi_wstrb[0];
          end
          if ((aw_got_ff || (s_axi_awvalid && s_axi_awready)) &&
              (w_got_ff || (s_axi_wvalid && s_axi_wready))) begin
            wst_ff <= W_HOLD;
          end
        end
        W_HOLD: begin
          bresp_ff <= addr_ok_w ? RESP_OKAY : RESP_SLVERR;
          wst_ff   <= W_RESP;
        end
        W_RESP: begin
          if (s_axi_bready) begin
            wst_ff    <= W_IDLE;
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
          end
        end
        default: wst_ff <= W_IDLE;
      endcase
    end
  end

  assign s_axi_bvalid = (wst_ff == W_RESP);
  assign s_axi_bresp  = bresp_ff;

  // Configuration registers; only byte lane 0 holds data
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_a_ff <= '{sel: PIN_A_SEL_RST, pol: POL_RST}; // RULE_01 RULE_09
      cfg_b_ff <= '{sel: PIN_B_SEL_RST, pol: POL_RST}; // RULE_11 RULE_12
    end else if (wr_fire && wstrb0_ff) begin
      if (waddr_ff == IDX_PIN_A) begin
        cfg_a_ff.sel <= wdata_ff[SEL_MSB:SEL_LSB]; // RULE_01
        cfg_a_ff.pol <= wdata_ff[POL_BIT];         // RULE_09
      end
      if (waddr_ff == IDX_PIN_B) begin
        cfg_b_ff.sel <= wdata_ff[SEL_MSB:SEL_LSB]; // RULE_11
        cfg_b_ff.pol <= wdata_ff[POL_BIT];         // RULE_12
      end
    end
  end

  // Events: loss of each reference and lock loss, on rising edge.
  // Detector bypass is deliberately not used here or in the pins.
  assign evt_now  = {ind.lock_loss, ind.sec_los, ind.pri_los}; // RULE_15
  assign evt_rise = evt_now & ~evt_prev_ff;
  assign st_clr   = (wr_fire && wstrb0_ff && waddr_ff == IDX_IRQ_ST) ?
                    wdata_ff[NUM_EVT-1:0] : '0;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      evt_prev_ff <= '0;
      irq_st_ff   <= '0;
      irq_msk_ff  <= '0;
    end else begin
      evt_prev_ff <= evt_now;
      // Set wins over a clear in the same cycle
      irq_st_ff   <= (irq_st_ff & ~st_clr) | evt_rise;
      if (wr_fire && wstrb0_ff && waddr_ff == IDX_IRQ_MSK) begin
        irq_msk_ff <= wdata_ff[NUM_EVT-1:0];
      end
    end
  end

  assign irq = |(irq_st_ff & irq_msk_ff);

  // Read channel
  assign s_axi_arready = !rvalid_ff;
  assign ridx = s_axi_araddr[9:2];

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_rok   = 1'b1;
    unique case (ridx)
      IDX_PIN_A:   nxt_rdata[7:0] = {cfg_a_ff, 3'b000}; // RULE_14
      IDX_PIN_B:   nxt_rdata[7:0] = {cfg_b_ff, 3'b000}; // RULE_14
      IDX_IRQ_ST:  nxt_rdata[NUM_EVT-1:0] = irq_st_ff;
      IDX_IRQ_MSK: nxt_rdata[NUM_EVT-1:0] = irq_msk_ff;
      default:     nxt_rok = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

  // Interrupt summary on the pins follows the block's own flags
  always_comb begin
    ind_eff      = ind;
    ind_eff.interrupt_indication = ind.interrupt_indication | irq; // RULE_06
  end

  sps_pin_mux u_pin_a (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .cfg     (cfg_a_ff),
    .ind     (ind_eff),
    .test    (test_a),
    .pin     (status_pin_a)
  );

  sps_pin_mux u_pin_b (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .cfg     (cfg_b_ff),
    .ind     (ind_eff),
    .test    (test_b),
    .pin     (status_pin_b)
  );

  sequence s_wr_sel_a;
    wr_fire && wstrb0_ff && waddr_ff == IDX_PIN_A;
  endsequence

  a_sel_a_write: assert property ( // RULE_01
    @(posedge ref_clk) disable iff (sys_rst)
    s_wr_sel_a |=> cfg_a_ff.sel == $past(wdata_ff[7:4]))
    else $error("pin A selector not updated");
  a_cfg_b_write: assert property ( // RULE_12
    @(posedge ref_clk) disable iff (sys_rst)
    (wr_fire && wstrb0_ff && waddr_ff == IDX_PIN_B)
    |=> cfg_b_ff.pol == $past(wdata_ff[3]))
    else $error("pin B polarity not updated");
  a_sel_takes: assert property ( // RULE_17
    @(posedge ref_clk) disable iff (sys_rst)
    (s_wr_sel_a ##1 (!test_a.enable && cfg_a_ff.sel == C_LOCK))
    |=> status_pin_a == ($past(ind.lock_loss) ~^ $past(cfg_a_ff.pol)))
    else $error("write not effective on pin");
  a_rsvd_read: assert property ( // RULE_14
    @(posedge ref_clk) disable iff (sys_rst)
    (s_axi_arvalid && s_axi_arready && ridx == IDX_PIN_B)
    |=> s_axi_rdata[2:0] == 3'b000)
    else $error("reserved bits not zero");
  a_b_override: assert property ( // RULE_13
    @(posedge ref_clk) disable iff (sys_rst)
    test_b.enable |=> status_pin_b == $past(test_b.level))
    else $error("pin B test override missing");
  a_irq_set: assert property ( // RULE_15
    @(posedge ref_clk) disable iff (sys_rst)
    evt_rise[0] |=> irq_st_ff[0])
    else $error("loss event not flagged");
endmodule : sps_top
`default_nettype wire

// ===== src/sps_pkg.sv
// What this block does
// [RULE_01] Pin A selector bits 7:4, reset 0x5
// [RULE_02] Codes 0,1,2 route signal/lock loss
// [RULE_03] Code 3: reference divider halved
// [RULE_04] Code 4: feedback divider halved
// [RULE_05] Code 8: VCO calibration active
// [RULE_06] Code 10: interrupt indication from flags
// [RULE_07] Code 11: post divider halved
// [RULE_08] Code 13 memory busy, 14 auto switch
// [RULE_09] Pin A polarity bit 3, reset 1
// [RULE_10] Test configuration overrides pin A selection
// [RULE_11] Pin B selector bits 7:4, reset 0x2
// [RULE_12] Pin B polarity bit 3, reset 1
// [RULE_13] Test configuration overrides pin B selection
// [RULE_14] Bits 2:0 reserved, read zero
// [RULE_15] Detector bypass never alters loss indications
// [RULE_16] Reserved codes drive inactive level
// [RULE_17] Selection combinational from register fields
//
// Purpose: constants and types for the status pin source select block
// Assumes: one clock, AXI4-Lite register access
// Notes:   offsets are word indices; byte address is four times index
`default_nettype none
package sps_pkg;
  localparam logic [7:0] IDX_PIN_A   = 8'h1b;
  localparam logic [7:0] IDX_PIN_B   = 8'h1c;
  localparam logic [7:0] IDX_IRQ_ST  = 8'h40;
  localparam logic [7:0] IDX_IRQ_MSK = 8'h41;
  localparam int SEL_MSB = 7;
  localparam int SEL_LSB = 4;
  localparam int POL_BIT = 3;
  localparam logic [3:0] PIN_A_SEL_RST = 4'h5;
  localparam logic [3:0] PIN_B_SEL_RST = 4'h2;
  localparam logic       POL_RST       = 1'b1;
  localparam logic [3:0] C_PRI_LOS  = 4'h0;
  localparam logic [3:0] C_SEC_LOS  = 4'h1;
  localparam logic [3:0] C_LOCK     = 4'h2;
  localparam logic [3:0] C_RDIV     = 4'h3;
  localparam logic [3:0] C_NDIV     = 4'h4;
  localparam logic [3:0] C_CAL      = 4'h8;
  localparam logic [3:0] C_INTERRUPT_INDICATION     = 4'ha;
  localparam logic [3:0] C_MDIV     = 4'hb;
  localparam logic [3:0] C_NVM      = 4'hd;
  localparam logic [3:0] C_SWITCH   = 4'he;
  localparam int NUM_EVT = 3;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic pri_los;
    logic sec_los;
    logic lock_loss;
    logic rdiv_out;
    logic ndiv_out;
    logic cal_active;
    logic interrupt_indication;
    logic mdiv_out;
    logic nvm_active;
    logic auto_switch;
  } sps_ind_t;

  typedef struct packed {
    logic [3:0] sel;
    logic       pol;
  } sps_pin_cfg_t;

  typedef struct packed {
    logic enable;
    logic level;
  } sps_test_t;
endpackage : sps_pkg
`default_nettype wire

// ===== src/sps_pin_mux.sv
// Purpose: one status pin: source select, polarity, test override
// Assumes: indicators synchronous to ref_clk
// Notes:   output registered so the pin is glitch free
`default_nettype none
module sps_pin_mux (
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  input  wire sps_pkg::sps_pin_cfg_t cfg,
  input  wire sps_pkg::sps_ind_t     ind,
  input  wire sps_pkg::sps_test_t    test,
  output var  logic                  pin
);
  import sps_pkg::*;

  logic raw;
  logic nxt_pin;
  logic pin_ff;

  always_comb begin
    unique case (cfg.sel)
      C_PRI_LOS: raw = ind.pri_los;     // RULE_02
      C_SEC_LOS: raw = ind.sec_los;     // RULE_02
      C_LOCK:    raw = ind.lock_loss;   // RULE_02
      C_RDIV:    raw = ind.rdiv_out;    // RULE_03
      C_NDIV:    raw = ind.ndiv_out;    // RULE_04
      C_CAL:     raw = ind.cal_active;  // RULE_05
      C_INTERRUPT_INDICATION:    raw = ind.interrupt_indication;        // RULE_06
      C_MDIV:    raw = ind.mdiv_out;    // RULE_07
      C_NVM:     raw = ind.nvm_active;  // RULE_08
      C_SWITCH:  raw = ind.auto_switch; // RULE_08
      default:   raw = 1'b0;            // RULE_16
    endcase
  end

  // Active low inverts, so reserved codes still sit inactive
  always_comb begin
    nxt_pin = cfg.pol ? raw : ~raw;     // RULE_09 RULE_12 RULE_17
    if (test.enable) begin
      nxt_pin = test.level;             // RULE_10 RULE_13
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_ff <= 1'b0;
    end else begin
      pin_ff <= nxt_pin;
    end
  end

  assign pin = pin_ff;

  a_test_override: assert property ( // RULE_10
    @(posedge ref_clk) disable iff (sys_rst)
    test.enable |=> pin == $past(test.level))
    else $error("test override not applied");
  a_reserved_idle: assert property ( // RULE_16
    @(posedge ref_clk) disable iff (sys_rst)
    (!test.enable && cfg.sel inside {4'h5, 4'h6, 4'h7, 4'h9, 4'hc, 4'hf})
    |=> pin == !$past(cfg.pol))
    else $error("reserved code not at inactive level");
  a_los_route: assert property ( // RULE_02
    @(posedge ref_clk) disable iff (sys_rst)
    (!test.enable && cfg.sel == C_PRI_LOS)
    |=> pin == ($past(ind.pri_los) ~^ $past(cfg.pol)))
    else $error("primary loss not routed");
  a_interrupt_indication_route: assert property ( // RULE_06
    @(posedge ref_clk) disable iff (sys_rst)
    (!test.enable && cfg.sel == C_INTERRUPT_INDICATION)
    |=> pin == ($past(ind.interrupt_indication) ~^ $past(cfg.pol)))
    else $error("interrupt not routed");
  a_cal_route: assert property ( // RULE_05
    @(posedge ref_clk) disable iff (sys_rst)
    (!test.enable && cfg.sel == C_CAL)
    |=> pin == ($past(ind.cal_active) ~^ $past(cfg.pol)))
    else $error("calibration not routed");
endmodule : sps_pin_mux
`default_nettype wire

// ===== sim/sps_ind_model.sv
// Purpose: board-side source of the internal indicators seen by the pins
// Assumes: indicators are levels synchronous to ref_clk
// Notes:   registered so every change lands just after a clock edge
`default_nettype none
module sps_ind_model
  import sps_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic [9:0]        want,
  output var  sps_pkg::sps_ind_t ind
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge ref_clk) begin
    ind <= sps_ind_t'(want);
  end
endmodule : sps_ind_model
`default_nettype wire

// ===== sim/sps_top_tb.sv
// Purpose: self-checking bench for the status pin source select block
// Assumes: AXI4-Lite master here, indicator model on the far side
// Notes:   pins are checked a few cycles after each change settles
`default_nettype none
module sps_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sps_pkg::*;
  logic ref_clk, sys_rst, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [9:0] awa, ara, want;
  logic [31:0] wd, rd;
  logic [1:0] bresp, rresp;
  logic pin_a, pin_b, irq, byp;
  logic [3:0] ws;
  sps_ind_t ind;
  sps_test_t ta, tb;
  int failures, check_count;
  // Indicator position for each selector code, -1 where reserved
  int pos [16] = '{0, 1, 2, 3, 4, -1, -1, -1, 5, -1, 6, 7, -1, 8, 9, -1};

  sps_ind_model i_model (.ref_clk(ref_clk), .want(want), .ind(ind));
  sps_top i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .ind(ind), .signal_detector_bypass(byp),
    .test_a(ta), .test_b(tb), .status_pin_a(pin_a), .status_pin_b(pin_b),
    .irq(irq));

  task automatic stop_test();
    if (failures == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic axw(input logic [7:0] i, input logic [31:0] d,
                     input logic [1:0] er);
    logic a, w;
    a = 1'b0;
    w = 1'b0;
    awa <= {i, 2'b00}; awv <= 1'b1; wd <= d; wv <= 1'b1; br <= 1'b1;
    while (!(a && w)) begin
      @(posedge ref_clk);
      if (!a && awr) begin a = 1'b1; awv <= 1'b0; end
      if (!w && wr) begin w = 1'b1; wv <= 1'b0; end
    end
    do @(posedge ref_clk); while (!bv);
    br <= 1'b0;
    chk(bresp, er);
    @(posedge ref_clk);
  endtask : axw

  task automatic axr(input logic [7:0] i, input logic [31:0] e,
                     input logic [1:0] er);
    ara <= {i, 2'b00}; arv <= 1'b1; rr <= 1'b1;
    do @(posedge ref_clk); while (!arr);
    arv <= 1'b0;
    while (!rv) @(posedge ref_clk);
    rr <= 1'b0;
    chk(rd, e);
    chk(rresp, er);
    @(posedge ref_clk);
  endtask : axr

  task automatic settle(input logic [9:0] v);
    want <= v;
    repeat (4) @(posedge ref_clk);
  endtask : settle

  task automatic t_reset();
    axr(IDX_PIN_A, 32'h58, RESP_OKAY);
    axr(IDX_PIN_B, 32'h28, RESP_OKAY);
    chk(pin_a, 1'b0);
  endtask : t_reset

  task automatic t_codes();
    logic e;
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 16; c++) begin
        axw(IDX_PIN_A, {24'h0, c[3:0], p[0], 3'h0}, RESP_OKAY);
        axw(IDX_PIN_B, {24'h0, c[3:0], p[0], 3'h0}, RESP_OKAY);
        for (int k = 0; k < 11; k++) begin
          settle(k < 10 ? 10'h200 >> k : 10'h0);
          e = (pos[c] == k) ^ ~p[0];
          chk(pin_a, e);
          chk(pin_b, e);
        end
      end
    end
  endtask : t_codes

  task automatic t_space();
    axw(IDX_PIN_A, 32'hffff_ffff, RESP_OKAY);
    axr(IDX_PIN_A, 32'hf8, RESP_OKAY);
    // Lane 0 disabled: the write is answered but must not land
    ws <= 4'he;
    axw(IDX_PIN_A, 32'h0000_0018, RESP_OKAY);
    ws <= 4'hf;
    axr(IDX_PIN_A, 32'hf8, RESP_OKAY);
    axw(IDX_PIN_B, 32'h0000_00f7, RESP_OKAY);
    axr(IDX_PIN_B, 32'hf0, RESP_OKAY);
    axw(8'h30, 32'h1, RESP_SLVERR);
    axr(8'h30, 32'h0, RESP_SLVERR);
  endtask : t_space

  task automatic t_override();
    axw(IDX_PIN_A, 32'h08, RESP_OKAY);
    axw(IDX_PIN_B, 32'h28, RESP_OKAY);
    ta <= '{enable: 1'b1, level: 1'b1};
    tb <= '{enable: 1'b1, level: 1'b0};
    settle(10'h080);
    chk(pin_a, 1'b1);
    chk(pin_b, 1'b0);
    ta <= '{enable: 1'b0, level: 1'b1};
    tb <= '{enable: 1'b0, level: 1'b0};
    settle(10'h080);
    chk(pin_a, 1'b0);
    chk(pin_b, 1'b1);
  endtask : t_override

  task automatic t_bypass();
    byp <= 1'b1;
    settle(10'h200);
    chk(pin_a, 1'b1);
    byp <= 1'b0;
  endtask : t_bypass

  task automatic t_irq();
    settle(10'h0);
    axw(IDX_IRQ_ST, 32'h7, RESP_OKAY);
    axw(IDX_IRQ_MSK, 32'h1, RESP_OKAY);
    chk(irq, 1'b0);
    settle(10'h200);
    chk(irq, 1'b1);
    axr(IDX_IRQ_ST, 32'h1, RESP_OKAY);
    axw(IDX_IRQ_MSK, 32'h0, RESP_OKAY);
    chk(irq, 1'b0);
    axw(IDX_IRQ_MSK, 32'h1, RESP_OKAY);
    chk(irq, 1'b1);
    // Code 10 must follow the sticky flags, not only the raw input
    axw(IDX_PIN_A, 32'ha8, RESP_OKAY);
    chk(pin_a, 1'b1);
    settle(10'h0);
    axw(IDX_IRQ_ST, 32'h1, RESP_OKAY);
    chk(irq, 1'b0);
    chk(pin_a, 1'b0);
  endtask : t_irq

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    stop_test();
  end

  initial begin
    sys_rst = 1'b1; awv = 1'b0; wv = 1'b0; br = 1'b0; arv = 1'b0;
    rr = 1'b0; awa = '0; ara = '0; wd = '0; want = '0; byp = 1'b0;
    ta = '0; tb = '0; ws = 4'hf; failures = 0; check_count = 0;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    t_reset();
    t_codes();
    t_space();
    t_override();
    t_bypass();
    t_irq();
    stop_test();
  end
endmodule : sps_top_tb
`default_nettype wire
